// >>> ptg_pulse_train_unit.sv
//Contract
// - start trigger begins a new train with the latest written settings
// - run enable low stops pulse output at once, as emergency stop
// - start width is the first acceleration pulse width, ten microsecond units
// - acceleration count sets the number of ramp-up pulses, ramp is automatic
// - move width is the constant-speed pulse width, ten microsecond units
// - stop width is the width reached at the end of deceleration; here the last pulse stays one per-pulse ramp step short
// - deceleration count sets the number of ramp-down pulses
// - total count is all phases together; exactly that many pulses are sent
// - a zero ramp count skips that ramp phase
// - acceleration steps width from start width toward move width
// - deceleration steps width from move width toward stop width likewise; entered from acceleration it starts at the width reached
// - done goes low as soon as a train begins
// - done goes high when the total is sent and stays until next start
// - done can trigger the start of another generator
// - channel select 0 to 3 routes the train to that output line
// - pulse mode runs only after arm command then apply-reset command
`timescale 1ns/1ps
module ptg_pulse_train_unit #(
  parameter int unsigned W = 16,
  parameter int unsigned N = 32,
  parameter int unsigned UNIT_CYCLES = ptg_pkg::UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_trigger,
  input wire logic run_enable,
  output logic output_line_0,
  output logic output_line_1,
  output logic output_line_2,
  output logic output_line_3,
  output logic train_done,
  output logic irq
);

  logic [W-1:0] start_width, move_width, stop_width;
  logic [N-1:0] accel_count, decel_count, total_count;
  logic [1:0] channel;
  logic mode_arm, mode_active;
  logic [ptg_pkg::INT_BITS-1:0] int_status, int_enable;
  logic [W-1:0] l_move, l_stop;
  logic [N-1:0] l_accel, l_decel, l_total;
  logic [1:0] l_chan;
  ptg_pkg::ptg_state_type state;
  ptg_pkg::ptg_phase_type phase, next_phase;
  logic [W-1:0] cur_width, target_width, ramp_diff, entry_width, entry_target;
  logic [N-1:0] ramp_len, entry_len, emitted, emitted_inc;
  logic [N:0] ramp_err;
  logic [W-1:0] unit_count;
  logic [3:0] lines;
  logic [1:0] pins_s;
  logic start_q, tick;
  logic wr, setup, ext_rise, sw_start, apply, start_req, start_go;
  logic half_done, pulse_end, last_pulse, phase_change;
  logic ev_done, ev_abort, ev_refuse;
  logic [W-1:0] eff_width, src_move;
  logic run_en_s, start_s;

  assign wr = psel && penable && pwrite && pready;
  assign setup = psel && !penable;
  assign sw_start = wr && paddr == ptg_pkg::ADDR_CTRL && pwdata[ptg_pkg::CTRL_START_BIT];
  assign apply = wr && paddr == ptg_pkg::ADDR_CTRL && pwdata[ptg_pkg::CTRL_APPLY_BIT];

  ptg_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({run_enable, start_trigger}),
    .q(pins_s)
  );

  assign run_en_s = pins_s[1];
  assign start_s = pins_s[0];

  ptg_tick #(
    .CYCLES(UNIT_CYCLES)
  ) u_tick (
    .clk(pclk),
    .rst_n(presetn),
    .restart(start_go),
    .tick(tick)
  );

  // a rising edge lets another unit's done output chain into this one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_s;
    end
  end

  assign ext_rise = start_s && !start_q;
  assign start_req = ext_rise || sw_start;
  assign start_go = start_req && mode_active && run_en_s && !apply;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_width <= ptg_pkg::RST_WIDTH;
      move_width <= ptg_pkg::RST_WIDTH;
      stop_width <= ptg_pkg::RST_WIDTH;
      accel_count <= N'(ptg_pkg::RST_COUNT);
      decel_count <= N'(ptg_pkg::RST_COUNT);
      total_count <= N'(ptg_pkg::RST_COUNT);
      channel <= ptg_pkg::RST_CHAN;
      mode_arm <= 1'b0;
      int_enable <= '0;
    end else if (wr) begin
      if (paddr == ptg_pkg::ADDR_CTRL) begin
        mode_arm <= pwdata[ptg_pkg::CTRL_ARM_BIT];
        channel <= pwdata[ptg_pkg::CTRL_CHAN_LSB +: 2];
      end else if (paddr == ptg_pkg::ADDR_START_WIDTH) begin
        start_width <= pwdata[W-1:0];
      end else if (paddr == ptg_pkg::ADDR_ACCEL_COUNT) begin
        accel_count <= pwdata[N-1:0];
      end else if (paddr == ptg_pkg::ADDR_MOVE_WIDTH) begin
        move_width <= pwdata[W-1:0];
      end else if (paddr == ptg_pkg::ADDR_STOP_WIDTH) begin
        stop_width <= pwdata[W-1:0];
      end else if (paddr == ptg_pkg::ADDR_DECEL_COUNT) begin
        decel_count <= pwdata[N-1:0];
      end else if (paddr == ptg_pkg::ADDR_TOTAL_COUNT) begin
        total_count <= pwdata[N-1:0];
      end else if (paddr == ptg_pkg::ADDR_INT_ENABLE) begin
        int_enable <= pwdata[ptg_pkg::INT_BITS-1:0];
      end
    end
  end

  // the mode only changes on the apply-reset command, never mid-write of the arm bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_active <= 1'b0;
    end else if (apply) begin
      mode_active <= mode_arm;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == ptg_pkg::ADDR_CTRL) begin
        prdata[ptg_pkg::CTRL_ARM_BIT] <= mode_arm;
        prdata[ptg_pkg::CTRL_CHAN_LSB +: 2] <= channel;
      end else if (paddr == ptg_pkg::ADDR_START_WIDTH) begin
        prdata[W-1:0] <= start_width;
      end else if (paddr == ptg_pkg::ADDR_ACCEL_COUNT) begin
        prdata[N-1:0] <= accel_count;
      end else if (paddr == ptg_pkg::ADDR_MOVE_WIDTH) begin
        prdata[W-1:0] <= move_width;
      end else if (paddr == ptg_pkg::ADDR_STOP_WIDTH) begin
        prdata[W-1:0] <= stop_width;
      end else if (paddr == ptg_pkg::ADDR_DECEL_COUNT) begin
        prdata[N-1:0] <= decel_count;
      end else if (paddr == ptg_pkg::ADDR_TOTAL_COUNT) begin
        prdata[N-1:0] <= total_count;
      end else if (paddr == ptg_pkg::ADDR_STATUS) begin
        prdata[ptg_pkg::STAT_DONE_BIT] <= train_done;
        prdata[ptg_pkg::STAT_RUN_BIT] <= state != ptg_pkg::ST_IDLE;
        prdata[ptg_pkg::STAT_ACTIVE_BIT] <= mode_active;
        prdata[ptg_pkg::STAT_ARM_BIT] <= mode_arm;
        prdata[ptg_pkg::STAT_PHASE_LSB +: 3] <= phase;
      end else if (paddr == ptg_pkg::ADDR_EMITTED) begin
        prdata[N-1:0] <= emitted;
      end else if (paddr == ptg_pkg::ADDR_INT_STATUS) begin
        prdata[ptg_pkg::INT_BITS-1:0] <= int_status;
      end else if (paddr == ptg_pkg::ADDR_INT_ENABLE) begin
        prdata[ptg_pkg::INT_BITS-1:0] <= int_enable;
      end else if (paddr != ptg_pkg::ADDR_INT_CLEAR) begin
        pslverr <= 1'b1;
      end
    end
  end

  // a zero width would give no pulse at all, so it counts as one unit
  assign eff_width = (cur_width == '0) ? W'(1) : cur_width;
  assign half_done = tick && ({1'b0, unit_count} + (W + 1)'(1)) >= {1'b0, eff_width};
  assign pulse_end = state == ptg_pkg::ST_LOW && half_done;
  assign emitted_inc = emitted + N'(1);
  assign last_pulse = emitted_inc == l_total;

  function automatic ptg_pkg::ptg_phase_type phase_for(
    input logic [N-1:0] e,
    input logic [N-1:0] a,
    input logic [N-1:0] d,
    input logic [N-1:0] t
  );
    phase_for = ptg_pkg::PH_CONST;
    if (e < a) begin
      phase_for = ptg_pkg::PH_ACCEL;
    end else if ((t - e) <= d) begin
      phase_for = ptg_pkg::PH_DECEL;
    end
  endfunction

  always_comb begin
    src_move = start_go ? move_width : l_move;
    if (start_go) begin
      next_phase = phase_for('0, accel_count, decel_count, total_count);
    end else begin
      next_phase = phase_for(emitted_inc, l_accel, l_decel, l_total);
    end
    entry_width = cur_width;
    entry_target = src_move;
    entry_len = start_go ? accel_count : l_accel;
    case (next_phase)
      ptg_pkg::PH_ACCEL: begin
        entry_width = start_go ? start_width : cur_width;
      end
      ptg_pkg::PH_DECEL: begin
        entry_width = start_go ? src_move : cur_width;
        entry_target = start_go ? stop_width : l_stop;
        entry_len = start_go ? decel_count : l_decel;
      end
      default: begin
        entry_width = src_move;
      end
    endcase
  end

  assign phase_change = start_go || (pulse_end && !last_pulse && next_phase != phase);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l_move <= ptg_pkg::RST_WIDTH;
      l_stop <= ptg_pkg::RST_WIDTH;
      l_accel <= N'(ptg_pkg::RST_COUNT);
      l_decel <= N'(ptg_pkg::RST_COUNT);
      l_total <= N'(ptg_pkg::RST_COUNT);
      l_chan <= ptg_pkg::RST_CHAN;
    end else if (start_go) begin
      l_move <= move_width;
      l_stop <= stop_width;
      l_accel <= accel_count;
      l_decel <= decel_count;
      l_total <= total_count;
      // a start written together with a new channel goes to that new channel
      l_chan <= (wr && paddr == ptg_pkg::ADDR_CTRL) ?
                pwdata[ptg_pkg::CTRL_CHAN_LSB +: 2] : channel;
    end
  end

  // bresenham ramp: one width step per clock while the error covers the ramp length,
  // so very steep ramps on short pulses lag into the following pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= ptg_pkg::PH_CONST;
      cur_width <= ptg_pkg::RST_WIDTH;
      target_width <= ptg_pkg::RST_WIDTH;
      ramp_diff <= '0;
      ramp_len <= '0;
      ramp_err <= '0;
    end else if (phase_change) begin
      phase <= next_phase;
      cur_width <= entry_width;
      target_width <= entry_target;
      ramp_len <= entry_len;
      ramp_err <= '0;
      if (entry_target >= entry_width) begin
        ramp_diff <= entry_target - entry_width;
      end else begin
        ramp_diff <= entry_width - entry_target;
      end
    end else if (pulse_end && phase != ptg_pkg::PH_CONST) begin
      ramp_err <= ramp_err + (N + 1)'(ramp_diff);
    end else if (phase != ptg_pkg::PH_CONST && ramp_err >= {1'b0, ramp_len} &&
                 cur_width != target_width) begin
      ramp_err <= ramp_err - {1'b0, ramp_len};
      if (target_width > cur_width) begin
        cur_width <= cur_width + W'(1);
      end else begin
        cur_width <= cur_width - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ptg_pkg::ST_IDLE;
      unit_count <= '0;
      emitted <= '0;
      train_done <= 1'b0;
    end else if (apply) begin
      state <= ptg_pkg::ST_IDLE;
    end else if (start_go) begin
      unit_count <= '0;
      emitted <= '0;
      if (total_count == '0) begin
        state <= ptg_pkg::ST_IDLE;
        train_done <= 1'b1;
      end else begin
        state <= ptg_pkg::ST_HIGH;
        train_done <= 1'b0;
      end
    end else if (!run_en_s) begin
      state <= ptg_pkg::ST_IDLE;
    end else begin
      case (state)
        ptg_pkg::ST_HIGH: begin
          if (half_done) begin
            state <= ptg_pkg::ST_LOW;
            unit_count <= '0;
          end else if (tick) begin
            unit_count <= unit_count + W'(1);
          end
        end
        ptg_pkg::ST_LOW: begin
          if (pulse_end) begin
            emitted <= emitted_inc;
            unit_count <= '0;
            if (last_pulse) begin
              state <= ptg_pkg::ST_IDLE;
              train_done <= 1'b1;
            end else begin
              state <= ptg_pkg::ST_HIGH;
            end
          end else if (tick) begin
            unit_count <= unit_count + W'(1);
          end
        end
        default: begin
          state <= ptg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= 4'h0;
    end else if (mode_active && state == ptg_pkg::ST_HIGH) begin
      lines <= 4'h1 << l_chan;
    end else begin
      lines <= 4'h0;
    end
  end

  assign output_line_0 = lines[0];
  assign output_line_1 = lines[1];
  assign output_line_2 = lines[2];
  assign output_line_3 = lines[3];

  assign ev_done = pulse_end && last_pulse && run_en_s && !start_go && !apply;
  assign ev_abort = !run_en_s && state != ptg_pkg::ST_IDLE && !start_go && !apply;
  assign ev_refuse = start_req && !start_go;

  // a set arriving with its clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == ptg_pkg::ADDR_INT_CLEAR) begin
        int_status <= (int_status & ~pwdata[ptg_pkg::INT_BITS-1:0]) |
                      {ev_refuse, ev_abort, ev_done};
      end else begin
        int_status <= int_status | {ev_refuse, ev_abort, ev_done};
      end
      irq <= |(int_status & int_enable);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_start_runs;
    start_go && total_count != '0 |=> state == ptg_pkg::ST_HIGH && emitted == '0;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not run");

  property p_estop;
    !run_en_s && !start_go |=> state == ptg_pkg::ST_IDLE ##1 lines == 4'h0;
  endproperty
  a_estop: assert property (p_estop) else $error("enable low did not stop");

  property p_first_width;
    start_go && accel_count != '0 |=> cur_width == $past(start_width) && phase == ptg_pkg::PH_ACCEL;
  endproperty
  a_first_width: assert property (p_first_width) else $error("bad first width");

  property p_const_width;
    state != ptg_pkg::ST_IDLE && phase == ptg_pkg::PH_CONST |-> cur_width == l_move;
  endproperty
  a_const_width: assert property (p_const_width) else $error("bad constant width");

  property p_skip_accel;
    start_go && accel_count == '0 && total_count > decel_count |=> phase == ptg_pkg::PH_CONST;
  endproperty
  a_skip_accel: assert property (p_skip_accel) else $error("ramp not skipped");

  property p_count_bound;
    state != ptg_pkg::ST_IDLE |-> emitted < l_total;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("too many pulses");

  property p_done_low;
    start_go && total_count != '0 |=> !train_done;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done not low on start");

  property p_done_high;
    ev_done |=> train_done && state == ptg_pkg::ST_IDLE ##1 train_done || $past(start_go);
  endproperty
  a_done_high: assert property (p_done_high) else $error("done not high at end");

  property p_abort_done;
    ev_abort |=> !train_done && state == ptg_pkg::ST_IDLE;
  endproperty
  a_abort_done: assert property (p_abort_done) else $error("abort raised done");

  property p_one_line;
    $onehot0(lines) and (!mode_active |=> lines == 4'h0);
  endproperty
  a_one_line: assert property (p_one_line) else $error("wrong output line");

  cover property (ev_done);
  cover property (ev_abort);
  cover property (state != ptg_pkg::ST_IDLE && phase == ptg_pkg::PH_DECEL);
  cover property (ev_refuse);

endmodule

// >>> ptg_pkg.sv
package ptg_pkg;

  // clock and ramp time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned UNIT_TIME_US = 10;
  // least time, so rounded up to whole cycles
  localparam int unsigned UNIT_CYCLES = (UNIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_START_WIDTH = 12'h004;
  localparam logic [11:0] ADDR_ACCEL_COUNT = 12'h008;
  localparam logic [11:0] ADDR_MOVE_WIDTH = 12'h00c;
  localparam logic [11:0] ADDR_STOP_WIDTH = 12'h010;
  localparam logic [11:0] ADDR_DECEL_COUNT = 12'h014;
  localparam logic [11:0] ADDR_TOTAL_COUNT = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01c;
  localparam logic [11:0] ADDR_EMITTED = 12'h020;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h024;
  localparam logic [11:0] ADDR_INT_ENABLE = 12'h028;
  localparam logic [11:0] ADDR_INT_CLEAR = 12'h02c;

  // control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ARM_BIT = 1;
  localparam int unsigned CTRL_APPLY_BIT = 2;
  localparam int unsigned CTRL_CHAN_LSB = 4;

  // status register fields
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_RUN_BIT = 1;
  localparam int unsigned STAT_ACTIVE_BIT = 2;
  localparam int unsigned STAT_ARM_BIT = 3;
  localparam int unsigned STAT_PHASE_LSB = 4;

  // interrupt bits
  localparam int unsigned INT_DONE_BIT = 0;
  localparam int unsigned INT_ABORT_BIT = 1;
  localparam int unsigned INT_REFUSE_BIT = 2;
  localparam int unsigned INT_BITS = 3;

  // reset values
  localparam logic [15:0] RST_WIDTH = 16'h0000;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [1:0] RST_CHAN = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b100
  } ptg_state_type;

  typedef enum logic [2:0] {
    PH_ACCEL = 3'b001,
    PH_CONST = 3'b010,
    PH_DECEL = 3'b100
  } ptg_phase_type;

endpackage

// >>> ptg_sync.sv
`timescale 1ns/1ps
module ptg_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// >>> ptg_tick.sv
`timescale 1ns/1ps
module ptg_tick #(
  parameter int unsigned CYCLES = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // restart aligns the time base with the first edge of a train
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      // start one cycle into the period so the first half is as long as the rest
      count <= (CYCLES > 1) ? CW'(1) : '0;
      tick <= (CYCLES == 1);
    end else if (count == LAST) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule

// >>> ptg_drive_model.sv
`timescale 1ns/1ps
module ptg_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic [3:0] lines,
  output logic [31:0] pulses [4],
  output logic [31:0] first_width,
  output logic [31:0] min_width
);
  logic [3:0] prev;
  logic [31:0] run;

  // a step input only counts rising edges and times each high half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 4'h0;
      run <= 32'h0;
      first_width <= 32'h0;
      min_width <= 32'hffff_ffff;
      for (int i = 0; i < 4; i++) pulses[i] <= 32'h0;
    end else if (clear) begin
      run <= 32'h0;
      first_width <= 32'h0;
      min_width <= 32'hffff_ffff;
      for (int i = 0; i < 4; i++) pulses[i] <= 32'h0;
    end else begin
      prev <= lines;
      for (int i = 0; i < 4; i++) begin
        if (lines[i] && !prev[i]) pulses[i] <= pulses[i] + 32'h1;
      end
      if (|lines) begin
        run <= run + 32'h1;
      end else if (run != 32'h0) begin
        if (first_width == 32'h0) first_width <= run;
        if (run < min_width) min_width <= run;
        run <= 32'h0;
      end
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned UC = 4;
  logic pclk, presetn, psel, penable, pwrite, start_trigger, run_enable, clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, snap;
  logic pready, pslverr, er, train_done, irq;
  logic [3:0] lines;
  logic [31:0] pulses [4];
  logic [31:0] first_width, min_width;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  ptg_pulse_train_unit #(.UNIT_CYCLES(UC)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_trigger(start_trigger),
    .run_enable(run_enable), .output_line_0(lines[0]), .output_line_1(lines[1]),
    .output_line_2(lines[2]), .output_line_3(lines[3]), .train_done(train_done), .irq(irq));
  ptg_drive_model drv_u (.pclk(pclk), .presetn(presetn), .clear(clear), .lines(lines),
    .pulses(pulses), .first_width(first_width), .min_width(min_width));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // the limit covers all scenarios with a wide margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 40000) begin
      errors++;
      finish_test;
    end
  end

  task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task set_train(input logic [31:0] sw, ac, mw, stw, dc, tot);
    apb(1'b1, ptg_pkg::ADDR_START_WIDTH, sw);
    apb(1'b1, ptg_pkg::ADDR_ACCEL_COUNT, ac);
    apb(1'b1, ptg_pkg::ADDR_MOVE_WIDTH, mw);
    apb(1'b1, ptg_pkg::ADDR_STOP_WIDTH, stw);
    apb(1'b1, ptg_pkg::ADDR_DECEL_COUNT, dc);
    apb(1'b1, ptg_pkg::ADDR_TOTAL_COUNT, tot);
  endtask

  task clr;
    @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
  endtask

  task start(input logic [31:0] ctrl);
    clr;
    apb(1'b1, ptg_pkg::ADDR_CTRL, ctrl);
    repeat (3) @(negedge pclk);
    chk_bit("train_done", 1'b0, train_done);
  endtask

  task wait_done;
    int n;
    n = 0;
    while (train_done !== 1'b1 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    chk_bit("train_done", 1'b1, train_done);
  endtask

  task t_reset;
    apb(1'b0, ptg_pkg::ADDR_TOTAL_COUNT, 32'h0);
    chk_word("total_count", ptg_pkg::RST_COUNT, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk_bit("pslverr", 1'b1, er);
    chk_bit("irq", 1'b0, irq);
  endtask

  task t_refused;
    set_train(32'h2, 32'h0, 32'h2, 32'h2, 32'h0, 32'h2);
    apb(1'b1, ptg_pkg::ADDR_CTRL, 32'h1);
    repeat (50) @(negedge pclk);
    chk_word("pulses", 32'h0, pulses[0]);
    apb(1'b0, ptg_pkg::ADDR_INT_STATUS, 32'h0);
    chk_bit("refused", 1'b1, rd[ptg_pkg::INT_REFUSE_BIT]);
    apb(1'b1, ptg_pkg::ADDR_INT_CLEAR, 32'h7);
    apb(1'b1, ptg_pkg::ADDR_CTRL, 32'h2);
    apb(1'b1, ptg_pkg::ADDR_CTRL, 32'h6);
    apb(1'b0, ptg_pkg::ADDR_STATUS, 32'h0);
    chk_bit("mode_active", 1'b1, rd[ptg_pkg::STAT_ACTIVE_BIT]);
  endtask

  task t_const;
    set_train(32'h5, 32'h0, 32'h2, 32'h2, 32'h0, 32'h3);
    start(32'h3);
    wait_done;
    chk_word("pulses", 32'h3, pulses[0]);
    chk_word("first_width", 2 * UC, first_width);
    repeat (20) @(negedge pclk);
    chk_bit("train_done", 1'b1, train_done);
  endtask

  task t_channels;
    apb(1'b1, ptg_pkg::ADDR_TOTAL_COUNT, 32'h1);
    for (int i = 0; i < 4; i++) begin
      start(32'h3 | 32'(i << ptg_pkg::CTRL_CHAN_LSB));
      wait_done;
      chk_word("line_pulses", 32'h1, pulses[i]);
      chk_word("all_pulses", 32'h1, pulses[0] + pulses[1] + pulses[2] + pulses[3]);
    end
  endtask

  task t_ramp;
    set_train(32'h4, 32'h2, 32'h1, 32'h3, 32'h2, 32'h8);
    apb(1'b1, ptg_pkg::ADDR_INT_CLEAR, 32'h1);
    apb(1'b1, ptg_pkg::ADDR_INT_ENABLE, 32'h1);
    start(32'h3);
    chk_bit("irq", 1'b0, irq);
    wait_done;
    chk_word("pulses", 32'h8, pulses[0]);
    chk_word("first_width", 4 * UC, first_width);
    chk_word("min_width", 1 * UC, min_width);
    repeat (2) @(negedge pclk);
    chk_bit("irq", 1'b1, irq);
    apb(1'b1, ptg_pkg::ADDR_INT_ENABLE, 32'h0);
    repeat (2) @(negedge pclk);
    chk_bit("irq", 1'b0, irq);
    apb(1'b1, ptg_pkg::ADDR_INT_ENABLE, 32'h1);
    repeat (2) @(negedge pclk);
    chk_bit("irq", 1'b1, irq);
    apb(1'b1, ptg_pkg::ADDR_INT_CLEAR, 32'h1);
    repeat (2) @(negedge pclk);
    chk_bit("irq", 1'b0, irq);
  endtask

  task t_abort;
    int n;
    n = 0;
    set_train(32'h2, 32'h0, 32'h2, 32'h2, 32'h0, 32'd50);
    start(32'h3);
    while (pulses[0] < 32'h2 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    run_enable <= 1'b0;
    repeat (5) @(negedge pclk);
    chk_word("lines", 32'h0, {28'h0, lines});
    snap = pulses[0];
    repeat (40) @(negedge pclk);
    chk_bit("train_done", 1'b0, train_done);
    chk_word("pulses", snap, pulses[0]);
    apb(1'b0, ptg_pkg::ADDR_INT_STATUS, 32'h0);
    chk_bit("abort", 1'b1, rd[ptg_pkg::INT_ABORT_BIT]);
    @(posedge pclk);
    run_enable <= 1'b1;
    repeat (40) @(negedge pclk);
    chk_bit("train_done", 1'b0, train_done);
    chk_word("pulses", snap, pulses[0]);
  endtask

  task t_pin;
    set_train(32'h2, 32'h0, 32'h3, 32'h3, 32'h0, 32'h0);
    apb(1'b1, ptg_pkg::ADDR_CTRL, 32'h3);
    repeat (2) @(negedge pclk);
    chk_bit("train_done", 1'b1, train_done);
    apb(1'b1, ptg_pkg::ADDR_TOTAL_COUNT, 32'h2);
    clr;
    @(posedge pclk);
    start_trigger <= 1'b1;
    repeat (6) @(negedge pclk);
    chk_bit("train_done", 1'b0, train_done);
    wait_done;
    chk_word("pulses", 32'h2, pulses[0]);
    chk_word("first_width", 3 * UC, first_width);
    @(posedge pclk);
    start_trigger <= 1'b0;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    start_trigger = 1'b0;
    run_enable = 1'b1;
    clear = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_refused;
    t_const;
    t_channels;
    t_ramp;
    t_abort;
    t_pin;
    finish_test;
  end
endmodule
